// *** common/rdc_err_if.sv ***
// Carrier between the core and its per-domain violation store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rdc_err_if;
    logic        cap_valid;
    logic [2:0]  cap_dom;
    logic [31:0] cap_addr;
    logic        clr_valid;
    logic [2:0]  clr_dom;
    logic [2:0]  own_dom;
    logic [2:0]  sel_dom;
    logic        own_pend;
    logic        own_multi;
    logic [31:0] own_addr;
    logic        sel_pend;
    logic        sel_multi;
    logic [31:0] sel_addr;

    modport core  (output cap_valid, cap_dom, cap_addr, clr_valid, clr_dom, own_dom, sel_dom,
                   input own_pend, own_multi, own_addr, sel_pend, sel_multi, sel_addr);
    modport store (input cap_valid, cap_dom, cap_addr, clr_valid, clr_dom, own_dom, sel_dom,
                   output own_pend, own_multi, own_addr, sel_pend, sel_multi, sel_addr);
endinterface : rdc_err_if

// *** common/rdc_pkg.sv ***
// Constants for the resource domain controller core: register offsets,
// field positions, reset values and attribute encodings.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
package rdc_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DID_W  = 3;

    // Register offsets (byte addresses, one word each).
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_HWCFG    = 8'h04;
    localparam logic [7:0] OFF_CURDID   = 8'h08;
    localparam logic [7:0] OFF_LOCKS    = 8'h0C;
    localparam logic [7:0] OFF_FLW_CTRL = 8'h10;
    localparam logic [7:0] OFF_FLW_BASE = 8'h14;
    localparam logic [7:0] OFF_FLW_SIZE = 8'h18;
    localparam logic [7:0] OFF_ERR_SEL  = 8'h1C;
    localparam logic [7:0] OFF_ERR_OWN  = 8'h20;
    localparam logic [7:0] OFF_ERR_OADR = 8'h24;
    localparam logic [7:0] OFF_ERR_SADR = 8'h28;
    localparam logic [7:0] OFF_ASG_BASE = 8'h40;

    // Control register bits.
    localparam int CTRL_GVALID_BIT  = 0;
    localparam int CTRL_PROC_EN_BIT = 1;

    // Assignment word fields.
    localparam int ASG_DID_LSB    = 0;
    localparam int ASG_DSEL_LSB   = 4;
    localparam int ASG_SEC_LSB    = 6;
    localparam int ASG_PRIV_BIT   = 8;
    localparam int ASG_BYPASS_BIT = 9;
    localparam int ASG_VALID_BIT  = 29;
    localparam int ASG_LOCK_BIT   = 31;
    localparam logic [31:0] ASG_WMASK = 32'hA00003F7;
    localparam logic [31:0] ASG_RST   = 32'h00000000;

    // Processor lock bits: secure and non-secure vector base, protection, attribution.
    localparam int LOCK_W = 5;

    // Flash logical window fields; one size count is 32k bytes.
    localparam int FLW_EN_BIT    = 0;
    localparam int FLW_LOCK_BIT  = 31;
    localparam int FLW_SIZE_W    = 16;
    localparam int FLW_UNIT_LOG2 = 15;

    // Error status fields.
    localparam int ERR_PEND_BIT  = 31;
    localparam int ERR_MULTI_BIT = 30;
    localparam int ERR_CLR_BIT   = 31;

    // Default instance sizes.
    localparam int NUM_MASTERS_DEF = 4;
    localparam int NUM_ASSIGN_DEF  = 2;
    localparam int NUM_DOMAINS_DEF = 8;
    localparam int NUM_MRC_DEF     = 2;
    localparam int NUM_PCHK_DEF    = 2;

    // Domain identifier select encodings.
    typedef enum logic [1:0] {
        DSEL_OWN   = 2'h0,
        DSEL_INPUT = 2'h1,
        DSEL_MIX   = 2'h2,
        DSEL_RSVD  = 2'h3
    } dsel_e;

    // Secure attribute encodings.
    typedef enum logic [1:0] {
        SEC_FORCE  = 2'h0,
        SEC_NONSEC = 2'h1,
        SEC_PASS0  = 2'h2,
        SEC_PASS1  = 2'h3
    } sec_sel_e;

endpackage : rdc_pkg

// *** core/rdc_err_store.sv ***
// Per-domain store of the first captured access violation.
// Assumes at most one capture and one clear per cycle, same clock as the core.
`timescale 1ns/1ps
module rdc_err_store #(
    parameter int ND = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    rdc_err_if.store err
);

    logic        pend_q  [ND];
    logic        multi_q [ND];
    logic [31:0] addr_q  [ND];

    // One record per domain; a capture in the clearing cycle wins so no event is lost.
    for (genvar d = 0; d < ND; d++)
    begin : g_dom
        wire cap_d = err.cap_valid && (err.cap_dom == 3'(d));
        wire clr_d = err.clr_valid && (err.clr_dom == 3'(d));
        always_ff @(posedge clk_in)
        begin
            if (rst_in)
            begin
                pend_q[d]  <= 1'b0;
                multi_q[d] <= 1'b0;
                addr_q[d]  <= 32'h00000000;
            end
            else if (cap_d && (!pend_q[d] || clr_d))
            begin
                pend_q[d]  <= 1'b1;
                multi_q[d] <= 1'b0;
                addr_q[d]  <= err.cap_addr;
            end
            else if (cap_d)
                multi_q[d] <= 1'b1;
            else if (clr_d)
            begin
                pend_q[d]  <= 1'b0;
                multi_q[d] <= 1'b0;
            end
        end

        chk_err_first_kept: assert property (@(posedge clk_in) disable iff (rst_in)
            pend_q[d] && !clr_d |=> pend_q[d] && $stable(addr_q[d]))
            else $error("first pending violation was lost");
        chk_err_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
            clr_d && !cap_d |=> !pend_q[d])
            else $error("violation not cleared");
    end

    // Read ports for the requesting domain and the selected domain.
    wire own_ok = 32'(err.own_dom) < ND;
    wire sel_ok = 32'(err.sel_dom) < ND;
    assign err.own_pend  = own_ok && pend_q[err.own_dom];
    assign err.own_multi = own_ok && multi_q[err.own_dom];
    assign err.own_addr  = own_ok ? addr_q[err.own_dom] : 32'h00000000;
    assign err.sel_pend  = sel_ok && pend_q[err.sel_dom];
    assign err.sel_multi = sel_ok && multi_q[err.sel_dom];
    assign err.sel_addr  = sel_ok ? addr_q[err.sel_dom] : 32'h00000000;

endmodule : rdc_err_store

// *** core/resource_domain_controller_core.sv ***
// Resource domain controller core: master domain assignment, processor
// lock controls, flash logical window and per-domain violation reporting.
// Assumes a same-clock register master and same-clock bus master attributes.
//
// Behaviour
// - Global-valid for domain assignment stays set once written until reset.
// - A locked assignment word ignores every write until reset.
// - Each assignment has a valid bit; invalid assignments never hit.
// - Master and assignment index together pick the applied assignment word.
// - One enable switches the processor master's assignments on or off.
// - Non-processor words hold domain, privilege, secure, bypass and lock.
// - A register read returns the reading master's domain identifier.
// - Read-only config reports masters, domains, region and peripheral checkers.
// - Sticky locks freeze vector bases, protection and attribution settings.
// - A disabled flash window applies no remapping.
// - A locked flash window ignores writes to all its registers.
// - Window size counts 32k-byte units; physical base is readable.
// - Violations captured per domain; first one and pending flag shown.
// - Any selected domain's first violation can be read and cleared.
// - Processor domain select: own bits, input, mixed, or reserved.
// - Secure attribute forces secure, non-secure, or passes through.
`timescale 1ns/1ps
module resource_domain_controller_core #(
    parameter int NM   = rdc_pkg::NUM_MASTERS_DEF,
    parameter int NA   = rdc_pkg::NUM_ASSIGN_DEF,
    parameter int ND   = rdc_pkg::NUM_DOMAINS_DEF,
    parameter int NMRC = rdc_pkg::NUM_MRC_DEF,
    parameter int NPAC = rdc_pkg::NUM_PCHK_DEF,
    localparam int MW  = $clog2(NM),
    localparam int AW  = $clog2(NA)
) (
    // Clock and reset.
    input  wire logic                      SYS_CLK_IN,
    input  wire logic                      RST_IN,
    // Register port.
    input  wire logic [rdc_pkg::ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic [rdc_pkg::DATA_W-1:0] REG_WDATA_IN,
    input  wire logic                      REG_WR_IN,
    input  wire logic                      REG_RD_IN,
    input  wire logic [MW-1:0]             REG_MASTER_IN,
    input  wire logic [2:0]                REG_DID_IN,
    output logic      [rdc_pkg::DATA_W-1:0] REG_RDATA_OUT,
    // Bus master access attributes.
    input  wire logic                      ACC_REQ_IN,
    input  wire logic [MW-1:0]             ACC_MASTER_IN,
    input  wire logic [AW-1:0]             ACC_ASSIGN_IN,
    input  wire logic [2:0]                ACC_DID_IN,
    input  wire logic                      ACC_SECURE_IN,
    input  wire logic                      ACC_PRIV_IN,
    output logic                           ACC_HIT_OUT,
    output logic      [2:0]                ACC_DID_OUT,
    output logic                           ACC_SECURE_OUT,
    output logic                           ACC_PRIV_OUT,
    // Access violation capture.
    input  wire logic                      VIOL_IN,
    input  wire logic [2:0]                VIOL_DID_IN,
    input  wire logic [31:0]               VIOL_ADDR_IN,
    // Processor locks and flash window.
    output logic      [rdc_pkg::LOCK_W-1:0] LOCK_CFG_OUT,
    output logic                           FLW_EN_OUT,
    output logic      [31:0]               FLW_END_OUT
);

    localparam int NW = NM * NA;
    localparam int KW = $clog2(NW);

    // Sizes outside the checked ranges are refused; the decode serves at most 48 assignment words.
    if (NM < 2 || NM > 16 || NA < 2 || NA > 8 || ND < 1 || ND > 8 || NMRC > 255 || NPAC > 255)
    begin : g_bad_size
        $error("resource_domain_controller_core: unsupported size parameters");
    end

    localparam logic [31:0] HWCFG = {8'(NPAC), 8'(NMRC), 8'(ND), 8'(NM)};

    // Domain of a master from its assignment word (shared by access and read paths).
    function automatic logic [2:0] dom_of(input logic [31:0] w, input logic proc, input logic [2:0] did_in);
        logic [1:0] sel;
        sel = w[rdc_pkg::ASG_DSEL_LSB +: 2];
        if (!proc)
            dom_of = w[rdc_pkg::ASG_BYPASS_BIT] ? did_in : w[2:0];
        else
        begin
            unique case (rdc_pkg::dsel_e'(sel))
                rdc_pkg::DSEL_OWN:   dom_of = w[2:0];
                rdc_pkg::DSEL_INPUT: dom_of = did_in;
                rdc_pkg::DSEL_MIX:   dom_of = {w[2], did_in[1:0]};
                rdc_pkg::DSEL_RSVD:  dom_of = w[2:0]; // Reserved treated as own bits.
            endcase
        end
    endfunction : dom_of

    // Control state.
    logic                       gvalid_q;
    logic                       proc_en_q;
    logic [rdc_pkg::LOCK_W-1:0] lock_q;
    logic                       flw_en_q;
    logic                       flw_lock_q;
    logic [31:0]                flw_base_q;
    logic [rdc_pkg::FLW_SIZE_W-1:0] flw_size_q;
    logic [2:0]                 sel_dom_q;
    logic [31:0]                asg_q [NW];
    logic [31:0]                rd_d;

    rdc_err_if err ();

    // Write decodes.
    wire wr_ctrl = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_CTRL;
    wire wr_lock = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_LOCKS;
    wire wr_flwc = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_FLW_CTRL;
    wire wr_flwb = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_FLW_BASE;
    wire wr_flws = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_FLW_SIZE;
    wire wr_esel = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_ERR_SEL;
    wire wr_eown = REG_WR_IN && REG_ADDR_IN == rdc_pkg::OFF_ERR_OWN;
    wire in_asg  = REG_ADDR_IN >= rdc_pkg::OFF_ASG_BASE;
    wire [7:0] asg_off = REG_ADDR_IN - rdc_pkg::OFF_ASG_BASE;
    wire [5:0] asg_idx = asg_off[7:2];
    wire asg_hit = in_asg && 32'(asg_idx) < NW;

    // Global valid is set-only and proc enable toggles freely; clearing valid is ignored.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            gvalid_q  <= 1'b0;
            proc_en_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            gvalid_q  <= gvalid_q | REG_WDATA_IN[rdc_pkg::CTRL_GVALID_BIT];
            proc_en_q <= REG_WDATA_IN[rdc_pkg::CTRL_PROC_EN_BIT];
        end
    end

    // Processor locks only ever set; a write of zero leaves them set.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
            lock_q <= '0;
        else if (wr_lock)
            lock_q <= lock_q | REG_WDATA_IN[rdc_pkg::LOCK_W-1:0];
    end

    // Flash window registers; the lock freezes them all, itself included.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            flw_en_q   <= 1'b0;
            flw_lock_q <= 1'b0;
            flw_base_q <= 32'h00000000;
            flw_size_q <= '0;
        end
        else if (!flw_lock_q)
        begin
            if (wr_flwc)
            begin
                flw_en_q   <= REG_WDATA_IN[rdc_pkg::FLW_EN_BIT];
                flw_lock_q <= REG_WDATA_IN[rdc_pkg::FLW_LOCK_BIT];
            end
            if (wr_flwb)
                flw_base_q <= REG_WDATA_IN;
            if (wr_flws)
                flw_size_q <= REG_WDATA_IN[rdc_pkg::FLW_SIZE_W-1:0];
        end
    end

    // Window end in bytes; held at zero while disabled so no remap can apply.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
            FLW_END_OUT <= 32'h00000000;
        else if (flw_en_q)
            FLW_END_OUT <= flw_base_q + (32'(flw_size_q) << rdc_pkg::FLW_UNIT_LOG2);
        else
            FLW_END_OUT <= 32'h00000000;
    end

    // Assignment words, one per master and index; a locked word keeps its value.
    for (genvar k = 0; k < NW; k++)
    begin : g_asg
        always_ff @(posedge SYS_CLK_IN)
        begin
            if (RST_IN)
                asg_q[k] <= rdc_pkg::ASG_RST;
            else if (REG_WR_IN && asg_hit && 32'(asg_idx) == k && !asg_q[k][rdc_pkg::ASG_LOCK_BIT])
                asg_q[k] <= REG_WDATA_IN & rdc_pkg::ASG_WMASK;
        end

        chk_asg_locked: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
            asg_q[k][rdc_pkg::ASG_LOCK_BIT] |=> $stable(asg_q[k]))
            else $error("locked assignment changed");
    end

    // Selected word for the access in flight.
    wire [KW-1:0] acc_k = KW'(32'(ACC_MASTER_IN) * NA + 32'(ACC_ASSIGN_IN));
    wire          acc_in_range = 32'(ACC_MASTER_IN) < NM;
    wire [31:0]   acc_w = acc_in_range ? asg_q[acc_k] : 32'h00000000;
    wire          acc_proc = ACC_MASTER_IN == '0;
    wire          acc_ok = ACC_REQ_IN && gvalid_q && acc_w[rdc_pkg::ASG_VALID_BIT]
                           && (!acc_proc || proc_en_q);
    wire [1:0]    acc_sec_sel = acc_w[rdc_pkg::ASG_SEC_LSB +: 2];

    // Registered attributes for the access; a miss leaves domain and attributes at zero.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN || !acc_ok)
        begin
            ACC_HIT_OUT    <= 1'b0;
            ACC_DID_OUT    <= 3'h0;
            ACC_SECURE_OUT <= 1'b0;
            ACC_PRIV_OUT   <= 1'b0;
        end
        else
        begin
            ACC_HIT_OUT <= 1'b1;
            ACC_DID_OUT <= dom_of(acc_w, acc_proc, ACC_DID_IN);
            // Processors keep their own security and privilege.
            if (acc_proc)
            begin
                ACC_SECURE_OUT <= ACC_SECURE_IN;
                ACC_PRIV_OUT   <= ACC_PRIV_IN;
            end
            else
            begin
                unique case (rdc_pkg::sec_sel_e'(acc_sec_sel))
                    rdc_pkg::SEC_FORCE:  ACC_SECURE_OUT <= 1'b1;
                    rdc_pkg::SEC_NONSEC: ACC_SECURE_OUT <= 1'b0;
                    rdc_pkg::SEC_PASS0:  ACC_SECURE_OUT <= ACC_SECURE_IN;
                    rdc_pkg::SEC_PASS1:  ACC_SECURE_OUT <= ACC_SECURE_IN;
                endcase
                // Privilege bit clear forces user mode, set passes the master's own.
                ACC_PRIV_OUT <= acc_w[rdc_pkg::ASG_PRIV_BIT] & ACC_PRIV_IN;
            end
        end
    end

    // Domain of the master reading the registers, from its first assignment word.
    wire [KW-1:0] reg_k = KW'(32'(REG_MASTER_IN) * NA);
    wire [31:0]   reg_w = 32'(REG_MASTER_IN) < NM ? asg_q[reg_k] : 32'h00000000;
    wire [2:0]    cur_did = dom_of(reg_w, REG_MASTER_IN == '0, REG_DID_IN);

    // Selected domain for the any-domain error view.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
            sel_dom_q <= 3'h0;
        else if (wr_esel)
            sel_dom_q <= REG_WDATA_IN[2:0];
    end

    // Store hookup; clearing a domain's record is done by a write, read stays side-effect free.
    assign err.cap_valid = VIOL_IN;
    assign err.cap_dom   = VIOL_DID_IN;
    assign err.cap_addr  = VIOL_ADDR_IN;
    assign err.own_dom   = cur_did;
    assign err.sel_dom   = sel_dom_q;
    assign err.clr_valid = (wr_esel && REG_WDATA_IN[rdc_pkg::ERR_CLR_BIT])
                           || (wr_eown && REG_WDATA_IN[rdc_pkg::ERR_CLR_BIT]);
    assign err.clr_dom   = wr_esel ? REG_WDATA_IN[2:0] : cur_did;

    rdc_err_store #(
        .ND (ND)
    ) u_err_store (
        .clk_in (SYS_CLK_IN),
        .rst_in (RST_IN),
        .err    (err)
    );

    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        rd_d = 32'h00000000;
        if (asg_hit)
            rd_d = asg_q[KW'(asg_idx)];
        else
        begin
            unique case (REG_ADDR_IN)
                rdc_pkg::OFF_CTRL:     rd_d = {30'h0, proc_en_q, gvalid_q};
                rdc_pkg::OFF_HWCFG:    rd_d = HWCFG;
                rdc_pkg::OFF_CURDID:   rd_d = {29'h0, cur_did};
                rdc_pkg::OFF_LOCKS:    rd_d = 32'(lock_q);
                rdc_pkg::OFF_FLW_CTRL: rd_d = {flw_lock_q, 30'h0, flw_en_q};
                rdc_pkg::OFF_FLW_BASE: rd_d = flw_base_q;
                rdc_pkg::OFF_FLW_SIZE: rd_d = 32'(flw_size_q);
                rdc_pkg::OFF_ERR_SEL:  rd_d = {err.sel_pend, err.sel_multi, 27'h0, sel_dom_q};
                rdc_pkg::OFF_ERR_OWN:  rd_d = {err.own_pend, err.own_multi, 27'h0, cur_did};
                rdc_pkg::OFF_ERR_OADR: rd_d = err.own_addr;
                rdc_pkg::OFF_ERR_SADR: rd_d = err.sel_addr;
                default:               rd_d = 32'h00000000;
            endcase
        end
    end

    // Read data stands one cycle after the strobe and is zero otherwise.
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN || !REG_RD_IN)
            REG_RDATA_OUT <= 32'h00000000;
        else
            REG_RDATA_OUT <= rd_d;
    end

    assign LOCK_CFG_OUT = lock_q;
    assign FLW_EN_OUT   = flw_en_q;

    // Checks.
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    chk_gvalid_sticky: assert property (gvalid_q |=> gvalid_q)
        else $error("global valid dropped");
    chk_invalid_miss: assert property (ACC_REQ_IN && !acc_w[rdc_pkg::ASG_VALID_BIT] |=> !ACC_HIT_OUT)
        else $error("invalid assignment hit");
    chk_proc_disabled: assert property (!proc_en_q && acc_proc |=> !ACC_HIT_OUT)
        else $error("disabled processor assignment hit");
    chk_locks_sticky: assert property ((lock_q & $past(lock_q)) == $past(lock_q))
        else $error("processor lock cleared");
    chk_flw_frozen: assert property (flw_lock_q |=> $stable({flw_en_q, flw_base_q, flw_size_q}) && flw_lock_q)
        else $error("locked flash window changed");
    chk_flw_off: assert property (!flw_en_q |=> FLW_END_OUT == 32'h00000000)
        else $error("disabled window still maps");
    chk_hwcfg_read: assert property (REG_RD_IN && REG_ADDR_IN == rdc_pkg::OFF_HWCFG |=> REG_RDATA_OUT == HWCFG)
        else $error("configuration read wrong");
    chk_curdid_read: assert property (REG_RD_IN && REG_ADDR_IN == rdc_pkg::OFF_CURDID
        |=> REG_RDATA_OUT[2:0] == $past(cur_did) && REG_RDATA_OUT[31:3] == 29'h0)
        else $error("current domain read wrong");

endmodule : resource_domain_controller_core

// *** tb/bus_master_model.sv ***
// Bus master model: issues one access attribute request at a time.
// Assumes the core samples the attributes on the rising edge while the request is high.
`timescale 1ns/1ps
module bus_master_model (
    // Clock.
    input  wire logic       clk_in,
    // Access attributes.
    output logic            req_out,
    output logic [1:0]      master_out,
    output logic [0:0]      assign_out,
    output logic [2:0]      did_out,
    output logic            secure_out,
    output logic            priv_out
);
    // Attributes start idle at time zero.
    initial
    begin
        {req_out, master_out, assign_out, did_out, secure_out, priv_out} = 9'h000;
    end

    // Idle attributes are inverted so a stale value never passes for a fresh request.
    task access(input logic [1:0] m, input logic [0:0] a, input logic [2:0] d, input logic s, input logic p);
        @(posedge clk_in);
        {req_out, master_out, assign_out, did_out, secure_out, priv_out} <= {1'b1, m, a, d, s, p};
        @(posedge clk_in);
        {req_out, master_out, assign_out, did_out, secure_out, priv_out} <= {1'b0, ~m, ~a, ~d, ~s, ~p};
    endtask : access
endmodule : bus_master_model

// *** tb/tb_top.sv ***
// Self-checking bench for the resource domain controller core.
// Assumes default instance sizes and a bench that drives every input after the rising edge.
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, fl_end, b, s, e, viol_addr = 32'h0;
    logic        wr_s = 1'b0, rd_s = 1'b0, viol = 1'b0, rd_d = 1'b0, acc_d = 1'b0;
    logic        a_req, a_sec, a_priv, hit, o_sec, o_priv, fl_en;
    logic [1:0]  reg_m = 2'h0, a_m;
    logic [0:0]  a_idx;
    logic [2:0]  reg_did = 3'h0, viol_did = 3'h0, a_did, o_did, d1, d2;
    logic [4:0]  locks;
    logic [31:0] expq[$];
    int          n_mismatch = 0, comparisons = 0, k;

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    resource_domain_controller_core DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_MASTER_IN(reg_m), .REG_DID_IN(reg_did), .REG_RDATA_OUT(rdata),
        .ACC_REQ_IN(a_req), .ACC_MASTER_IN(a_m), .ACC_ASSIGN_IN(a_idx), .ACC_DID_IN(a_did), .ACC_SECURE_IN(a_sec),
        .ACC_PRIV_IN(a_priv), .ACC_HIT_OUT(hit), .ACC_DID_OUT(o_did), .ACC_SECURE_OUT(o_sec),
        .ACC_PRIV_OUT(o_priv), .VIOL_IN(viol), .VIOL_DID_IN(viol_did), .VIOL_ADDR_IN(viol_addr),
        .LOCK_CFG_OUT(locks), .FLW_EN_OUT(fl_en), .FLW_END_OUT(fl_end));

    bus_master_model bm (.clk_in(clk), .req_out(a_req), .master_out(a_m), .assign_out(a_idx), .did_out(a_did),
        .secure_out(a_sec), .priv_out(a_priv));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task take(input logic [31:0] seen);
        if (expq.size() == 0) chk(seen, ~seen);
        else chk(seen, expq.pop_front());
    endtask : take

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] m);
        @(posedge clk);
        {addr, wdata, reg_m, reg_did, wr_s} <= {a, d, m, 3'($urandom), 1'b1};
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [1:0] m, input logic [31:0] x);
        expq.push_back(x);
        @(posedge clk);
        {addr, reg_m, rd_s} <= {a, m, 1'b1};
        @(posedge clk);
        rd_s <= 1'b0;
    endtask : rd

    task acc(input logic [1:0] m, input logic [0:0] i, input logic [2:0] d, input logic sc, input logic [5:0] x);
        expq.push_back({26'h0, x});
        bm.access(m, i, d, sc, 1'b1);
    endtask : acc

    task pulse(input logic [2:0] d, input logic [31:0] a);
        @(posedge clk);
        {viol, viol_did, viol_addr} <= {1'b1, d, a};
        @(posedge clk);
        viol <= 1'b0;
    endtask : pulse

    task wrap_up;
        if (expq.size() != 0) n_mismatch++;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // Read data and access answers stand for one cycle after their request, so look mid-cycle.
    always @(negedge clk)
    begin
        if (rd_d) take(rdata);
        if (acc_d) take({26'h0, hit, o_did, o_sec, o_priv});
        rd_d = rd_s;
        acc_d = a_req;
    end

    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        k = $urandom(67);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(rdc_pkg::OFF_HWCFG, 0, 32'h02020804);
        rd(8'h3C, 0, 32'h0);
        wr(rdc_pkg::OFF_CTRL, 3, 0);
        wr(rdc_pkg::OFF_CTRL, 0, 0);
        rd(rdc_pkg::OFF_CTRL, 0, 32'h1);
        d1 = 3'($urandom);
        wr(8'h48, 32'h20000100 | d1, 0);
        rd(8'h48, 0, 32'h20000100 | d1);
        acc(1, 0, ~d1, 0, {1'b1, d1, 2'b11});
        acc(1, 1, d1, 1, 6'h00);
        rd(rdc_pkg::OFF_CURDID, 1, 32'(d1));
        wr(8'h48, 32'hA0000100 | d1, 0);
        wr(8'h48, 32'h0, 0);
        rd(8'h48, 0, 32'hA0000100 | d1);
        for (k = 0; k < 4; k++)
        begin
            s = $urandom;
            wr(8'h50, 32'h20000005 | (k << 6), 0);
            acc(2, 0, 0, s[0], {4'hD, (k == 0) | (k > 1 && s[0]), 1'b0});
        end
        wr(8'h50, 32'h20000205, 0);
        acc(2, 0, d1, 0, {1'b1, d1, 2'b10});
        wr(8'h50, 32'h5, 0);
        acc(2, 0, 0, 0, 6'h00);
        wr(8'h40, 32'h20000000 | d1, 0);
        acc(0, 0, 0, 1, 6'h00);
        wr(rdc_pkg::OFF_CTRL, 2, 0);
        for (k = 0; k < 4; k++)
        begin
            d2 = 3'($urandom);
            wr(8'h40, 32'h20000000 | (k << 4) | d1, 0);
            acc(0, 0, d2, 1, {1'b1, (k == 1) ? d2 : (k == 2) ? {d1[2], d2[1:0]} : d1, 2'b11});
        end
        $display("Assignment tests done");
        wr(rdc_pkg::OFF_LOCKS, 5, 0);
        wr(rdc_pkg::OFF_LOCKS, 0, 0);
        rd(rdc_pkg::OFF_LOCKS, 0, 32'h5);
        chk(32'(locks), 32'h5);
        b = $urandom;
        s = $urandom & 32'hFFFF;
        wr(rdc_pkg::OFF_FLW_BASE, b, 0);
        wr(rdc_pkg::OFF_FLW_SIZE, s, 0);
        @(negedge clk);
        chk(fl_end, 32'h0);
        chk(32'(fl_en), 32'h0);
        wr(rdc_pkg::OFF_FLW_CTRL, 32'h80000001, 0);
        wr(rdc_pkg::OFF_FLW_BASE, ~b, 0);
        wr(rdc_pkg::OFF_FLW_CTRL, 0, 0);
        @(negedge clk);
        chk(fl_end, b + (s << 15));
        chk(32'(fl_en), 32'h1);
        rd(rdc_pkg::OFF_FLW_BASE, 0, b);
        rd(rdc_pkg::OFF_FLW_SIZE, 0, s);
        $display("Lock and window tests done");
        e = $urandom;
        pulse(d1, e);
        pulse(d1, ~e);
        wr(rdc_pkg::OFF_ERR_SEL, 32'(d1), 0);
        rd(rdc_pkg::OFF_ERR_SEL, 0, 32'hC0000000 | d1);
        rd(rdc_pkg::OFF_ERR_SADR, 0, e);
        rd(rdc_pkg::OFF_ERR_OWN, 1, 32'hC0000000 | d1);
        rd(rdc_pkg::OFF_ERR_OADR, 1, e);
        wr(rdc_pkg::OFF_ERR_OWN, 32'h80000000, 1);
        rd(rdc_pkg::OFF_ERR_SEL, 0, 32'(d1));
        d2 = d1 ^ 3'h1;
        pulse(d2, ~e);
        wr(rdc_pkg::OFF_ERR_SEL, 32'h80000000 | d2, 0);
        rd(rdc_pkg::OFF_ERR_SEL, 0, 32'(d2));
        $display("Violation tests done");
        repeat (3) @(posedge clk);
        wrap_up();
    end
endmodule : tb_top
